// ==== verilog/ebi_top.sv ====
`timescale 1ns/100ps
// Behaviour
// [RULE1] Bus address comes from core or display DMA fetch.
// [RULE2] Chip-select decode compares all 32 address bits.
// [RULE3] Address bits 15..0 are dedicated, no port function.
// [RULE4] Address bits 23..16 selectable as port; reset as address, zeros.
// [RULE5] Address bits 31..24 shared with port; reset to port function.
// [RULE6] Upper data byte always dedicated; 8-bit parts attach there.
// [RULE7] Eight-bit-system flag must be set before lower byte becomes port.
// [RULE8] In 16-bit or mixed systems lower byte stays data.
// [RULE9] Address strobe low with valid address; never during display DMA.
// [RULE10] Direction output high for read, low for write.
// [RULE11] Upper byte strobe for core word or even byte; not DMA.
// [RULE12] Lower byte strobe for core word or odd byte; not DMA.
// [RULE13] Write enables mark lanes; 8-bit regions use upper enable only.
// [RULE14] Acknowledge generated internally inside any chip-select range.
// [RULE15] Outside all ranges external logic drives acknowledge, pulled up.
// [RULE16] Output enable low on reads; also card read indication.
// [RULE17] Boot select after reset: six waits, all but register space.
// [RULE18] Each select pin select or port; group B select 3 resets input.
// [RULE19] Card write enable low for every card write.
// [RULE20] Card enables even/odd bytes, only under group D select 3.
// [RULE21] Boot width strap: low 8-bit, high 16-bit boot region.
// [RULE22] Core register reads stay internal; all writes appear externally.
// [RULE23] Internal acknowledge delayed by the select's wait states.
// [RULE24] Each shared pin has own function bit; port data, direction separate. Lower data byte instead switches as one on the 8-bit flag.
module ebi_top
  import ebi_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  // Core request and answer
  input wire ebi_req_t core_req,
  output logic core_ack,
  output logic [15:0] core_rdata,
  // Display DMA fetch request and answer
  input wire ebi_req_t dma_req,
  output logic dma_ack,
  // Configuration
  input wire ebi_cs_cfg_t [NUM_CS-1:0] cs_cfg_in,
  input wire logic cs_cfg_load,
  input wire logic eight_bit_system_flag,
  input wire logic boot_width_strap,
  input wire logic [7:0] pa_fsel,
  input wire logic [7:0] pf_fsel,
  input wire logic [NUM_CS-1:0] cs_fsel,
  input wire logic strobe_fsel,
  input wire logic card_fsel,
  input wire logic ack_pin_fsel,
  // Port data and direction held outside this block
  input wire ebi_port_t port_a_lines,
  input wire ebi_port_t port_f_lines,
  input wire ebi_port_t port_b_lines,
  input wire logic [NUM_CS-1:0] cs_port_data,
  input wire logic [NUM_CS-1:0] cs_port_dir,
  // Address pins
  output logic [15:0] addr_lo,
  output logic [7:0] pa_pin_out,
  output logic [7:0] pa_pin_oe,
  output logic [7:0] pf_pin_out,
  output logic [7:0] pf_pin_oe,
  // Data pins
  input wire logic [15:0] data_in,
  output logic [7:0] data_hi_out,
  output logic data_hi_oe,
  output logic [7:0] pb_pin_out,
  output logic [7:0] pb_pin_oe,
  // Bus control
  output logic address_strobe_n,
  output logic rd_wr,
  output logic upper_byte_strobe_n,
  output logic lower_byte_strobe_n,
  output logic high_byte_write_strobe_n,
  output logic low_byte_write_strobe_n,
  output logic output_enable_n,
  input wire logic transfer_acknowledge_n,
  // Chip selects and card
  output logic [NUM_CS-1:0] cs_pin_out,
  output logic [NUM_CS-1:0] cs_pin_oe,
  output logic card_write_n,
  output logic card_even_enable_n,
  output logic card_odd_enable_n,
  // Status
  output logic bus_busy,
  output logic boot_wide
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} ebi_state_t;

  ebi_state_t state_r;
  ebi_req_t cur_r;
  ebi_cs_cfg_t [NUM_CS-1:0] cfg_r;
  logic [3:0] wait_cnt_r;
  logic [NUM_CS-1:0] hit_r;
  logic ext_r;
  logic wide_r;
  logic strap_seen_r;
  logic boot_wide_r;
  logic [15:0] rdata_r;
  logic [NUM_CS-1:0] hit;
  logic any_hit;
  logic [3:0] ws;
  logic rwb;
  logic reg_space;
  logic [7:0] pb_bus_out;
  logic [7:0] pb_fsel;
  logic lane_hi;
  logic lane_lo;
  logic ack_now;
  ebi_req_t pick;
  logic take;

  // [RULE1] DMA fetch beats core; one master owns the bus
  always_comb begin
    pick = dma_req.valid ? dma_req : core_req;
    pick.dma = dma_req.valid;
  end

  ebi_cs_decode u_dec (
    .addr(pick.addr),
    .cfg(cfg_r),
    .hit(hit),
    .any_hit(any_hit),
    .wait_states(ws),
    .region_width_bit(rwb),
    .reg_space(reg_space)
  );

  assign take = (state_r == ST_IDLE) && pick.valid;

  // Strap caught on the first clock after reset release
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_seen_r <= 1'b0;
      boot_wide_r <= 1'b0;
    end else if (!strap_seen_r) begin
      strap_seen_r <= 1'b1;
      // [RULE21] strap sets boot width
      boot_wide_r <= boot_width_strap;
    end
  end

  // Chip-select windows; boot window set by reset
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_r <= '0;
      // [RULE17] boot select default window
      cfg_r[CS_BOOT].enable <= 1'b1;
      cfg_r[CS_BOOT].wait_states <= BOOT_WAIT_RST;
      cfg_r[CS_BOOT].mask <= '0;
      cfg_r[CS_BOOT].base <= '0;
      // Strap level ready for a request on the first edge after release
      cfg_r[CS_BOOT].region_width_bit <= boot_width_strap;
    end else if (cs_cfg_load) begin
      cfg_r <= cs_cfg_in;
    end else if (!strap_seen_r) begin
      cfg_r[CS_BOOT].region_width_bit <= boot_width_strap;
    end
  end

  // Bus cycle sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      cur_r <= '0;
      wait_cnt_r <= '0;
      hit_r <= '0;
      ext_r <= 1'b0;
      wide_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            cur_r <= pick;
            hit_r <= hit;
            wide_r <= rwb && !eight_bit_system_flag;
            wait_cnt_r <= ws;
            // [RULE22] core register reads stay off the bus
            ext_r <= !(reg_space && pick.read && !pick.dma);
            state_r <= (reg_space && pick.read && !pick.dma) ? ST_DONE : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (ack_now) begin
            state_r <= ST_DONE;
          end else if (wait_cnt_r != 4'h0) begin
            wait_cnt_r <= wait_cnt_r - 4'h1;
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
          ext_r <= 1'b0;
          cur_r.valid <= 1'b0;
          hit_r <= '0;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // [RULE14] internal acknowledge inside a window
  // [RULE23] after the programmed waits
  // [RULE15] external acknowledge otherwise, only via its pin
  // External line ignored inside a window, so a stray pulse cannot cut waits short
  always_comb begin
    if (|hit_r) begin
      ack_now = (wait_cnt_r == 4'h0);
    end else begin
      ack_now = ack_pin_fsel && !transfer_acknowledge_n;
    end
  end

  // Read data captured at acknowledge
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= '0;
    end else if (state_r == ST_WAIT && ack_now && cur_r.read) begin
      rdata_r <= data_in;
    end
  end

  assign core_ack = (state_r == ST_DONE) && !cur_r.dma;
  assign dma_ack = (state_r == ST_DONE) && cur_r.dma;
  assign core_rdata = rdata_r;
  assign bus_busy = state_r != ST_IDLE;
  assign boot_wide = boot_wide_r;

  // Byte lanes: word uses both, byte uses addr bit 0
  assign lane_hi = cur_r.word || !cur_r.addr[0];
  assign lane_lo = cur_r.word || cur_r.addr[0];

  // [RULE3] dedicated low address
  assign addr_lo = cur_r.addr[DED_ADDR_HI:0];

  // [RULE4] port A address lines, zero after reset
  ebi_pin_mux #(.W(8)) u_pa (
    .fsel(pa_fsel),
    .bus_out(cur_r.addr[PF_ADDR_LO-1:PA_ADDR_LO]),
    .bus_oe(8'hFF),
    .port_data(port_a_lines.dout),
    .port_dir(port_a_lines.oe),
    .pin_out(pa_pin_out),
    .pin_oe(pa_pin_oe)
  );

  // [RULE5] port F extended address
  ebi_pin_mux #(.W(8)) u_pf (
    .fsel(pf_fsel),
    .bus_out(cur_r.addr[ADDR_W-1:PF_ADDR_LO]),
    .bus_oe(8'hFF),
    .port_data(port_f_lines.dout),
    .port_dir(port_f_lines.oe),
    .pin_out(pf_pin_out),
    .pin_oe(pf_pin_oe)
  );

  // [RULE6] upper byte carries narrow data; odd byte moved up
  assign data_hi_out = (cur_r.word || !cur_r.addr[0] || wide_r) ?
                       cur_r.wdata[15:8] : cur_r.wdata[7:0];
  assign data_hi_oe = ext_r && !cur_r.read;

  // [RULE7] lower byte is port only with the 8-bit flag set
  // [RULE8] otherwise it stays data
  assign pb_fsel = eight_bit_system_flag ? 8'hFF : 8'h00;
  assign pb_bus_out = cur_r.wdata[7:0];
  ebi_pin_mux #(.W(8)) u_pb (
    .fsel(pb_fsel),
    .bus_out(pb_bus_out),
    .bus_oe({8{ext_r && !cur_r.read}}),
    .port_data(port_b_lines.dout),
    .port_dir(port_b_lines.oe),
    .pin_out(pb_pin_out),
    .pin_oe(pb_pin_oe)
  );

  // [RULE9] address strobe, not for DMA
  assign address_strobe_n = !(ext_r && !cur_r.dma);
  // [RULE10] read high, write low
  assign rd_wr = !ext_r || cur_r.read;
  // [RULE16] output enable on reads
  assign output_enable_n = !(ext_r && cur_r.read);

  // [RULE11] upper strobe
  // [RULE12] lower strobe
  assign upper_byte_strobe_n = !(strobe_fsel && ext_r && !cur_r.dma && lane_hi);
  assign lower_byte_strobe_n = !(strobe_fsel && ext_r && !cur_r.dma && lane_lo);

  // [RULE13] lane write enables; narrow regions use upper only
  assign high_byte_write_strobe_n = !(ext_r && !cur_r.read && (wide_r ? lane_hi : 1'b1));
  assign low_byte_write_strobe_n = !(ext_r && !cur_r.read && wide_r && lane_lo);

  // [RULE18] select pins, each select or port
  logic [NUM_CS-1:0] cs_bus_n;
  logic [NUM_CS-1:0] cs_fsel_eff;
  logic [NUM_CS-1:0] cs_dir_eff;
  assign cs_bus_n = ~(hit_r & {NUM_CS{ext_r}});
  assign cs_fsel_eff = ~cs_fsel;
  assign cs_dir_eff = cs_port_dir;
  ebi_pin_mux #(.W(NUM_CS)) u_cs (
    .fsel(cs_fsel_eff),
    .bus_out(cs_bus_n),
    .bus_oe({NUM_CS{1'b1}}),
    .port_data(cs_port_data),
    .port_dir(cs_dir_eff),
    .pin_out(cs_pin_out),
    .pin_oe(cs_pin_oe)
  );

  // [RULE19] card write strobe
  // [RULE20] card enables under group D select 3
  assign card_write_n = !(card_fsel && ext_r && !cur_r.read && hit_r[CS_GRP_D3]);
  assign card_even_enable_n = !(card_fsel && ext_r && hit_r[CS_GRP_D3] && lane_hi);
  assign card_odd_enable_n = !(card_fsel && ext_r && hit_r[CS_GRP_D3] && lane_lo);

  // Assertions
  // Display fetches keep the address strobe and both byte strobes high
  strobe_dma_a: assert property (@(posedge clk) disable iff (srst) // [RULE9]
    cur_r.dma |-> address_strobe_n && upper_byte_strobe_n && lower_byte_strobe_n)
    else $error("strobe during display fetch");
  rw_dir_a: assert property (@(posedge clk) disable iff (srst) // [RULE10]
    ext_r && cur_r.read |-> rd_wr && !output_enable_n)
    else $error("read direction wrong");
  reg_read_a: assert property (@(posedge clk) disable iff (srst) // [RULE22]
    take && reg_space && pick.read && !pick.dma |=> address_strobe_n && state_r == ST_DONE)
    else $error("register read seen on bus");
  wait_ack_a: assert property (@(posedge clk) disable iff (srst) // [RULE23]
    take && any_hit && ws == 4'h2 |=> !core_ack && !dma_ack ##1 !core_ack && !dma_ack
      ##1 state_r == ST_WAIT ##1 state_r == ST_DONE)
    else $error("wait states miscounted");
  boot_rst_a: assert property (@(posedge clk) // [RULE17]
    srst |=> cfg_r[CS_BOOT].enable && cfg_r[CS_BOOT].wait_states == 4'h6
      && cfg_r[CS_BOOT].mask == '0)
    else $error("boot select reset wrong");
  lane_we_a: assert property (@(posedge clk) disable iff (srst) // [RULE13]
    !wide_r |-> low_byte_write_strobe_n)
    else $error("lower write enable in narrow region");
  card_gate_a: assert property (@(posedge clk) disable iff (srst) // [RULE20]
    !hit_r[CS_GRP_D3] |-> card_even_enable_n && card_odd_enable_n && card_write_n)
    else $error("card enable outside select");
  pb_data_a: assert property (@(posedge clk) disable iff (srst) // [RULE8]
    !eight_bit_system_flag && ext_r && !cur_r.read |-> pb_pin_oe == 8'hFF)
    else $error("lower byte not driving data");
  ext_ack_a: assert property (@(posedge clk) disable iff (srst) // [RULE15]
    state_r == ST_WAIT && hit_r == '0 && transfer_acknowledge_n |=> state_r != ST_DONE)
    else $error("acknowledge without external input");
endmodule // ebi_top

// ==== verilog/ebi_pkg.sv ====
package ebi_pkg;
  // Pin counts
  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;
  localparam int NUM_CS = 16;
  localparam int WS_W = 4;
  // Address field positions
  localparam int DED_ADDR_HI = 15;
  localparam int PA_ADDR_LO = 16;
  localparam int PF_ADDR_LO = 24;
  // Chip-select slots: 0 boot, 1-3 group A, 4-7 group B, 8-11 group C, 12-15 group D
  localparam int CS_BOOT = 0;
  localparam int CS_GRP_B3 = 7;
  localparam int CS_GRP_D3 = 15;
  // Reset values
  localparam logic [3:0] BOOT_WAIT_RST = 4'h6;
  localparam logic [31:0] REG_SPACE_BASE = 32'hFFFF_F000;
  localparam logic [31:0] REG_SPACE_MASK = 32'hFFFF_F000;
  localparam logic [7:0] PA_FSEL_RST = 8'h00;
  localparam logic [7:0] PF_FSEL_RST = 8'hFF;
  localparam logic [15:0] CS_FSEL_RST = 16'h0001;
  localparam logic [15:0] CS_PEN_RST = 16'h0000;
  localparam logic [3:0] CS_WAIT_MAX = 4'hF;

  // One chip-select window
  typedef struct packed {
    logic [31:0] base;
    logic [31:0] mask;
    logic [3:0] wait_states;
    logic region_width_bit;
    logic enable;
  } ebi_cs_cfg_t;

  // Access request from an internal master
  typedef struct packed {
    logic valid;
    logic dma;
    logic read;
    logic word;
    logic [31:0] addr;
    logic [15:0] wdata;
  } ebi_req_t;

  // Port pin pair
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } ebi_port_t;
endpackage

// ==== verilog/ebi_cs_decode.sv ====
`timescale 1ns/100ps
module ebi_cs_decode
  import ebi_pkg::*;
(
  input wire logic [31:0] addr,
  input wire ebi_cs_cfg_t [NUM_CS-1:0] cfg,
  output logic [NUM_CS-1:0] hit,
  output logic any_hit,
  output logic [3:0] wait_states,
  output logic region_width_bit,
  output logic reg_space
);
  // Full 32-bit compare per window
  function automatic logic win_match(input logic [31:0] a, input ebi_cs_cfg_t c);
    win_match = c.enable && ((a & c.mask) == (c.base & c.mask));
  endfunction

  assign reg_space = (addr & REG_SPACE_MASK) == REG_SPACE_BASE;

  // [RULE2] full address decode
  genvar g;
  generate
    for (g = 0; g < NUM_CS; g++) begin : g_win
      assign hit[g] = win_match(addr, cfg[g]) && !reg_space;
    end
  endgenerate

  // Lowest hit wins; boot select has top priority
  always_comb begin
    any_hit = |hit;
    wait_states = '0;
    region_width_bit = 1'b0;
    for (int i = NUM_CS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        wait_states = cfg[i].wait_states;
        region_width_bit = cfg[i].region_width_bit;
      end
    end
  end
endmodule // ebi_cs_decode

// ==== verilog/ebi_pin_mux.sv ====
`timescale 1ns/100ps
module ebi_pin_mux
  import ebi_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic [W-1:0] fsel,
  input wire logic [W-1:0] bus_out,
  input wire logic [W-1:0] bus_oe,
  input wire logic [W-1:0] port_data,
  input wire logic [W-1:0] port_dir,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe
);
  // [RULE24] per-pin function select
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      assign pin_out[g] = fsel[g] ? port_data[g] : bus_out[g];
      assign pin_oe[g] = fsel[g] ? port_dir[g] : bus_oe[g];
    end
  endgenerate
endmodule // ebi_pin_mux

// ==== test/ebi_mem_model.sv ====
`timescale 1ns/100ps
module ebi_mem_model
  import ebi_pkg::*;
(
  input wire logic clk,
  input wire logic [15:0] addr_lo,
  input wire logic [7:0] data_hi_out,
  input wire logic [7:0] pb_pin_out,
  input wire logic address_strobe_n,
  input wire logic output_enable_n,
  input wire logic high_byte_write_strobe_n,
  input wire logic low_byte_write_strobe_n,
  input wire logic [NUM_CS-1:0] cs_pin_out,
  input wire logic [NUM_CS-1:0] cs_pin_oe,
  output logic [15:0] data_in,
  output logic transfer_acknowledge_n
);
  logic [15:0] mem_r [16];
  logic [15:0] last_r = 16'h0000;
  logic [1:0] ack_cnt_r = 2'h0;
  logic no_sel;

  // Byte lanes stored separately
  // lane writes
  always_ff @(posedge clk) begin
    if (!high_byte_write_strobe_n) begin
      mem_r[addr_lo[4:1]][15:8] <= data_hi_out;
    end
    if (!low_byte_write_strobe_n) begin
      mem_r[addr_lo[4:1]][7:0] <= pb_pin_out;
    end
  end

  // Released bus shows inverse of last value, so a stale read cannot match
  always_ff @(posedge clk) begin
    if (!output_enable_n) begin
      last_r <= mem_r[addr_lo[4:1]];
    end
  end
  assign data_in = !output_enable_n ? mem_r[addr_lo[4:1]] : ~last_r;

  // External acknowledge only when no select is driven low
  // external acknowledge, pulled up
  assign no_sel = &(cs_pin_out | ~cs_pin_oe);
  always_ff @(posedge clk) begin
    if (!address_strobe_n && no_sel) begin
      ack_cnt_r <= (ack_cnt_r == 2'h3) ? ack_cnt_r : ack_cnt_r + 2'h1;
    end else begin
      ack_cnt_r <= 2'h0;
    end
  end
  assign transfer_acknowledge_n = (ack_cnt_r < 2'h2);
endmodule // ebi_mem_model

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
  import ebi_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  ebi_req_t core_req, dma_req;
  ebi_cs_cfg_t [NUM_CS-1:0] cs_cfg_in;
  logic cs_cfg_load, eight_bit_system_flag, boot_width_strap, strobe_fsel, card_fsel;
  logic ack_pin_fsel, core_ack, dma_ack, data_hi_oe, address_strobe_n, rd_wr;
  logic upper_byte_strobe_n, lower_byte_strobe_n, high_byte_write_strobe_n;
  logic low_byte_write_strobe_n, output_enable_n, transfer_acknowledge_n;
  logic card_write_n, card_even_enable_n, card_odd_enable_n, bus_busy, boot_wide;
  logic [7:0] pa_fsel, pf_fsel, pa_pin_out, pa_pin_oe, pf_pin_out, pf_pin_oe;
  logic [7:0] data_hi_out, pb_pin_out, pb_pin_oe;
  ebi_port_t port_a_lines, port_f_lines, port_b_lines;
  logic [NUM_CS-1:0] cs_fsel, cs_port_data, cs_port_dir, cs_pin_out, cs_pin_oe;
  logic [15:0] core_rdata, addr_lo, data_in;
  logic [10:0] sig, seen;
  logic [31:0] a_seen;
  int n_mismatch = 0;
  int cmp_count = 0;

  ebi_top i_ebi_top (
    .clk(clk),
    .srst(srst),
    .core_req(core_req),
    .core_ack(core_ack),
    .core_rdata(core_rdata),
    .dma_req(dma_req),
    .dma_ack(dma_ack),
    .cs_cfg_in(cs_cfg_in),
    .cs_cfg_load(cs_cfg_load),
    .eight_bit_system_flag(eight_bit_system_flag),
    .boot_width_strap(boot_width_strap),
    .pa_fsel(pa_fsel),
    .pf_fsel(pf_fsel),
    .cs_fsel(cs_fsel),
    .strobe_fsel(strobe_fsel),
    .card_fsel(card_fsel),
    .ack_pin_fsel(ack_pin_fsel),
    .port_a_lines(port_a_lines),
    .port_f_lines(port_f_lines),
    .port_b_lines(port_b_lines),
    .cs_port_data(cs_port_data),
    .cs_port_dir(cs_port_dir),
    .addr_lo(addr_lo),
    .pa_pin_out(pa_pin_out),
    .pa_pin_oe(pa_pin_oe),
    .pf_pin_out(pf_pin_out),
    .pf_pin_oe(pf_pin_oe),
    .data_in(data_in),
    .data_hi_out(data_hi_out),
    .data_hi_oe(data_hi_oe),
    .pb_pin_out(pb_pin_out),
    .pb_pin_oe(pb_pin_oe),
    .address_strobe_n(address_strobe_n),
    .rd_wr(rd_wr),
    .upper_byte_strobe_n(upper_byte_strobe_n),
    .lower_byte_strobe_n(lower_byte_strobe_n),
    .high_byte_write_strobe_n(high_byte_write_strobe_n),
    .low_byte_write_strobe_n(low_byte_write_strobe_n),
    .output_enable_n(output_enable_n),
    .transfer_acknowledge_n(transfer_acknowledge_n),
    .cs_pin_out(cs_pin_out),
    .cs_pin_oe(cs_pin_oe),
    .card_write_n(card_write_n),
    .card_even_enable_n(card_even_enable_n),
    .card_odd_enable_n(card_odd_enable_n),
    .bus_busy(bus_busy),
    .boot_wide(boot_wide)
  );
  ebi_mem_model i_ebi_mem_model (
    .clk(clk),
    .addr_lo(addr_lo),
    .data_hi_out(data_hi_out),
    .pb_pin_out(pb_pin_out),
    .address_strobe_n(address_strobe_n),
    .output_enable_n(output_enable_n),
    .high_byte_write_strobe_n(high_byte_write_strobe_n),
    .low_byte_write_strobe_n(low_byte_write_strobe_n),
    .cs_pin_out(cs_pin_out),
    .cs_pin_oe(cs_pin_oe),
    .data_in(data_in),
    .transfer_acknowledge_n(transfer_acknowledge_n)
  );

  always #20 clk = ~clk;

  // Pins watched for a low level during a transfer
  assign sig = {address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n,
    high_byte_write_strobe_n, low_byte_write_strobe_n, output_enable_n,
    cs_pin_out[CS_BOOT], cs_pin_out[CS_GRP_D3], card_write_n,
    card_even_enable_n, card_odd_enable_n};

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic ebi_req_t rq(int d, int rd, int w, logic [31:0] a, logic [15:0] wd);
    return '{1'b1, d[0], rd[0], w[0], a, wd};
  endfunction

  // One transfer; lat 0 skips the latency check, mask picks the pins judged
  task automatic xfer(input ebi_req_t r, input int lat, input logic [10:0] exp,
      input logic [10:0] mask);
    int n;
    n = 0;
    seen = '0;
    @(negedge clk);
    if (r.dma) begin
      dma_req = r;
    end else begin
      core_req = r;
    end
    do begin
      @(negedge clk);
      n++;
      seen |= ~sig;
      if (!address_strobe_n) begin
        a_seen = {pf_pin_out, pa_pin_out, addr_lo};
      end
    end while (!(core_ack | dma_ack) && n < 60);
    if (n >= 60) begin
      n_mismatch++;
      $display("[FAIL] %0t transfer timed out", $time);
      end_of_test();
    end
    if (lat > 0) begin
      chk(n, lat, "ack latency");
    end
    chk(seen & mask, exp & mask, "strobe pattern");
    if (exp[10] & mask[10]) begin
      chk(a_seen[31:1], r.addr[31:1], "bus address");
    end
    core_req.valid = 1'b0;
    dma_req.valid = 1'b0;
  endtask

  task automatic t_reset();
    chk({address_strobe_n, rd_wr, output_enable_n}, 3'b111, "idle controls");
    chk({pa_pin_out, pa_pin_oe}, 16'h00FF, "upper address pins");
    chk({pf_pin_out, pf_pin_oe}, {port_f_lines.dout, port_f_lines.oe}, "port f");
    chk(cs_pin_oe[CS_GRP_B3], 1'b0, "group b select 3 input");
    chk(boot_wide, 1'b1, "boot width");
    chk({bus_busy, data_hi_oe}, 2'b00, "idle data drive");
    pf_fsel = 8'h00;
  endtask

  task automatic t_boot();
    xfer(rq(0, 0, 1, 32'h0000_0100, 16'hA5C3), 8, 11'h7D0, 11'h7FF);
    chk(rd_wr, 1'b0, "write direction");
    chk({bus_busy, data_hi_oe, data_hi_out}, 10'h3A5, "write data drive");
    xfer(rq(0, 1, 1, 32'h0000_0100, 16'h0000), 8, 11'h730, 11'h7FF);
    chk(rd_wr, 1'b1, "read direction");
    chk(core_rdata, 16'hA5C3, "read back");
    xfer(rq(0, 0, 0, 32'h0000_0102, 16'h1111), 8, 11'h690, 11'h7FF);
    xfer(rq(0, 0, 0, 32'h0000_0103, 16'h2222), 8, 11'h550, 11'h7FF);
  endtask

  task automatic t_special();
    xfer(rq(1, 1, 1, 32'h0000_0100, 16'h0000), 8, 11'h000, 11'h700);
    chk(addr_lo, 16'h0100, "display fetch address");
    xfer(rq(0, 1, 1, 32'hFFFF_F010, 16'h0000), 1, 11'h000, 11'h7FF);
    xfer(rq(0, 0, 1, 32'hFFFF_F010, 16'h0F0F), 0, 11'h400, 11'h400);
  endtask

  task automatic t_windows();
    cs_cfg_in = '0;
    cs_cfg_in[CS_GRP_D3] = '{32'h4000_0000, 32'hFF00_0000, 4'h2, 1'b1, 1'b1};
    cs_cfg_in[14] = '{32'h5000_0000, 32'hFF00_0000, 4'h0, 1'b0, 1'b1};
    @(negedge clk);
    cs_cfg_load = 1'b1;
    @(negedge clk);
    cs_cfg_load = 1'b0;
    xfer(rq(0, 0, 0, 32'h4000_0003, 16'h3333), 4, 11'h54D, 11'h7FF);
    xfer(rq(0, 0, 0, 32'h5000_0001, 16'h4444), 2, 11'h080, 11'h0C0);
    xfer(rq(0, 1, 1, 32'h2000_0000, 16'h0000), 0, 11'h720, 11'h7FF);
    chk(core_rdata, 16'h44C3, "unmapped read");
  endtask

  task automatic t_ports();
    eight_bit_system_flag = 1'b1;
    strobe_fsel = 1'b0;
    card_fsel = 1'b0;
    xfer(rq(0, 0, 1, 32'h4000_0000, 16'h6666), 4, 11'h488, 11'h7FF);
    pa_fsel = 8'h0F;
    cs_fsel[4] = 1'b0;
    @(negedge clk);
    chk({pa_pin_out[3:0], pa_pin_oe[3:0]}, 8'hCF, "port a pins");
    chk({cs_pin_out[4], cs_pin_oe[4]}, 2'b01, "select as port");
    chk({pb_pin_out, pb_pin_oe}, 16'h5AFF, "lower byte as port");
  endtask

  // Inputs settled at time zero, then changed on falling edges only
  initial begin
    core_req = '0;
    dma_req = '0;
    cs_cfg_in = '0;
    cs_cfg_load = 1'b0;
    eight_bit_system_flag = 1'b0;
    boot_width_strap = 1'b1;
    pa_fsel = PA_FSEL_RST;
    pf_fsel = PF_FSEL_RST;
    cs_fsel = CS_FSEL_RST | 16'h8010;
    strobe_fsel = 1'b1;
    card_fsel = 1'b1;
    ack_pin_fsel = 1'b1;
    port_a_lines = '{8'h3C, 8'hFF};
    port_f_lines = '{8'h96, 8'hF0};
    port_b_lines = '{8'h5A, 8'hFF};
    cs_port_data = '0;
    cs_port_dir = 16'h0010;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    t_reset();
    t_boot();
    t_special();
    t_windows();
    t_ports();
    end_of_test();
  end
endmodule // tb_top
